// ==== hw/afb_pkg.sv ====
// Package: constants, timing and carrier types for the async flash host controller
package afb_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int TMR_W = 8;

  // ****************************************
  // Timing, in ns as specified, and derived cycle counts
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_PD_MIN_NS = 100;
  // Wake and bus figures have no firm source; plain defaults
  localparam int T_WAKE_OUT_NS = 1000;
  localparam int T_WAKE_WR_NS = 1000;
  localparam int T_READ_ACC_NS = 100;
  localparam int T_WE_PULSE_NS = 100;
  localparam int T_WR_HOLD_NS = 24;
  localparam int T_BUS_GAP_NS = 40;

  // Least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [TMR_W-1:0] PD_HOLD_CYC = TMR_W'(ns_to_cyc(T_PD_MIN_NS));
  localparam logic [TMR_W-1:0] WAKE_OUT_CYC = TMR_W'(ns_to_cyc(T_WAKE_OUT_NS));
  localparam logic [TMR_W-1:0] WAKE_WR_CYC = TMR_W'(ns_to_cyc(T_WAKE_WR_NS));
  localparam logic [TMR_W-1:0] WAKE_CYC = (WAKE_OUT_CYC > WAKE_WR_CYC) ? WAKE_OUT_CYC : WAKE_WR_CYC;
  localparam logic [TMR_W-1:0] READ_ACC_CYC = TMR_W'(ns_to_cyc(T_READ_ACC_NS));
  localparam logic [TMR_W-1:0] WE_PULSE_CYC = TMR_W'(ns_to_cyc(T_WE_PULSE_NS));
  localparam logic [TMR_W-1:0] WR_HOLD_CYC = TMR_W'(ns_to_cyc(T_WR_HOLD_NS));
  localparam logic [TMR_W-1:0] BUS_GAP_CYC = TMR_W'(ns_to_cyc(T_BUS_GAP_NS));
  localparam logic [TMR_W-1:0] TMR_RST_VAL = 8'hFF;
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;
  localparam logic [7:0] BYTE_PAD = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_PWRDN = 2'h2
  } afb_op_t;

  typedef enum logic [2:0] {
    ST_PD_HOLD = 3'h0,
    ST_WAKE = 3'h1,
    ST_IDLE = 3'h3,
    ST_RD_ACC = 3'h2,
    ST_WR_PULSE = 3'h6,
    ST_WR_HOLD = 3'h7,
    ST_GAP = 3'h5
  } afb_state_t;

  typedef struct packed {
    afb_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic wide;
  } afb_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic [DATA_W-1:0] dq_oe;
    logic chip_select_a_n;
    logic chip_select_b_n;
    logic oe_n;
    logic we_n;
    logic power_down_reset_n;
    logic byte_wide;
  } afb_pins_t;

endpackage

// ==== hw/afb_cycle_timer.sv ====
// Down-counting cycle timer used to pace the flash bus phases
`timescale 1ns/1ps
module afb_cycle_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [afb_pkg::TMR_W-1:0] load_val,
  output logic expired
);
  import afb_pkg::*;

  logic [TMR_W-1:0] cnt_q;

  // Reset parks the count high so a reset pulse still gives a long power-down
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= TMR_RST_VAL;
    end else if (load) begin
      cnt_q <= load_val - TMR_ONE;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - TMR_ONE;
    end
  end

  assign expired = (cnt_q == '0);

endmodule

// ==== hw/afb_host.sv ====
// Host-side controller driving an asynchronous flash memory through its pins
// Contract
// - Host reads with both selects and output enable low, write strobe and reset high.
// - Reset pin low powers down the device; host holds it low 100 ns minimum.
// - Device wakes in read array, status 80H; host waits wake-to-output delay.
// - Host waits wake-to-write delay after raising reset before any command write.
// - Host drives the reset pin from the system reset.
// - Host supplies block or location address with erase, lock and program commands.
// - Host never drives output enable and write strobe low together.
`timescale 1ns/1ps
module afb_host (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire afb_pkg::afb_req_t req,
  output logic req_ready,
  output logic resp_valid,
  output logic [afb_pkg::DATA_W-1:0] resp_data,
  output logic dev_busy,
  output logic [afb_pkg::ADDR_W-1:0] flash_addr,
  output logic chip_select_a_n,
  output logic chip_select_b_n,
  output logic oe_n,
  output logic we_n,
  output logic power_down_reset_n,
  output logic byte_wide,
  input wire logic [afb_pkg::DATA_W-1:0] data_io_lines_in,
  output logic [afb_pkg::DATA_W-1:0] data_io_lines_out,
  output logic [afb_pkg::DATA_W-1:0] data_io_lines_oe,
  input wire logic ready_busy_output
);
  import afb_pkg::*;

  // ****************************************
  // Sequencer
  // ****************************************
  afb_state_t state_q, state_d;
  afb_pins_t pins_q;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_done;
  logic req_ready_q;
  logic accept;
  logic resp_valid_q;
  logic [DATA_W-1:0] resp_data_q;
  logic dev_busy_q;

  assign accept = req_valid && req_ready_q;

  function automatic logic [TMR_W-1:0] phase_cycles(input afb_state_t st);
    case (st)
      ST_PD_HOLD: phase_cycles = PD_HOLD_CYC;
      ST_WAKE: phase_cycles = WAKE_CYC;
      ST_RD_ACC: phase_cycles = READ_ACC_CYC;
      ST_WR_PULSE: phase_cycles = WE_PULSE_CYC;
      ST_WR_HOLD: phase_cycles = WR_HOLD_CYC;
      ST_GAP: phase_cycles = BUS_GAP_CYC;
      default: phase_cycles = TMR_ONE;
    endcase
  endfunction

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_PD_HOLD: begin
        if (tmr_done) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Covers both the output and the write wake delays
        if (tmr_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          case (req.op)
            OP_READ: state_d = ST_RD_ACC;
            OP_WRITE: state_d = ST_WR_PULSE;
            OP_PWRDN: state_d = ST_PD_HOLD;
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_RD_ACC: begin
        if (tmr_done) begin
          state_d = ST_GAP;
        end
      end
      ST_WR_PULSE: begin
        if (tmr_done) begin
          state_d = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        if (tmr_done) begin
          state_d = ST_GAP;
        end
      end
      ST_GAP: begin
        // Turnaround keeps a read's drivers off the bus before a write
        if (tmr_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_PD_HOLD;
    endcase
  end

  assign tmr_load = (state_d != state_q);
  assign tmr_val = phase_cycles(state_d);

  afb_cycle_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_done)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_PD_HOLD;
      req_ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_ready_q <= (state_d == ST_IDLE);
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pins_q.power_down_reset_n <= 1'b0;
      pins_q.chip_select_a_n <= 1'b1;
      pins_q.chip_select_b_n <= 1'b1;
      pins_q.oe_n <= 1'b1;
      pins_q.we_n <= 1'b1;
      pins_q.dq_oe <= '0;
    end else begin
      pins_q.power_down_reset_n <= (state_d != ST_PD_HOLD);
      // Select stays low through the hold so the strobe rises first
      pins_q.chip_select_a_n <= !(state_d inside {ST_RD_ACC, ST_WR_PULSE, ST_WR_HOLD});
      pins_q.chip_select_b_n <= !(state_d inside {ST_RD_ACC, ST_WR_PULSE, ST_WR_HOLD});
      pins_q.oe_n <= (state_d != ST_RD_ACC);
      pins_q.we_n <= (state_d != ST_WR_PULSE);
      pins_q.dq_oe <= {DATA_W{state_d inside {ST_WR_PULSE, ST_WR_HOLD}}};
    end
  end

  // Address, data and width are taken whole at acceptance of a read or write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pins_q.addr <= '0;
      pins_q.dq_out <= '0;
      pins_q.byte_wide <= 1'b1;
    end else if (accept && req.op != OP_PWRDN) begin
      pins_q.addr <= req.addr;
      pins_q.dq_out <= req.data;
      pins_q.byte_wide <= req.wide;
    end
  end

  // ****************************************
  // Read return and busy sampling
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_valid_q <= 1'b0;
      resp_data_q <= '0;
    end else begin
      resp_valid_q <= (state_q == ST_RD_ACC) && tmr_done;
      if ((state_q == ST_RD_ACC) && tmr_done) begin
        // In byte mode the upper lines float and are not trusted
        resp_data_q <= pins_q.byte_wide ? data_io_lines_in
                                        : {BYTE_PAD, data_io_lines_in[7:0]};
      end
    end
  end

  // Open-drain busy line floats high through the board pull-up when idle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dev_busy_q <= 1'b0;
    end else begin
      dev_busy_q <= !ready_busy_output;
    end
  end

  assign req_ready = req_ready_q;
  assign resp_valid = resp_valid_q;
  assign resp_data = resp_data_q;
  assign dev_busy = dev_busy_q;
  assign flash_addr = pins_q.addr;
  assign chip_select_a_n = pins_q.chip_select_a_n;
  assign chip_select_b_n = pins_q.chip_select_b_n;
  assign oe_n = pins_q.oe_n;
  assign we_n = pins_q.we_n;
  assign power_down_reset_n = pins_q.power_down_reset_n;
  assign byte_wide = pins_q.byte_wide;
  assign data_io_lines_out = pins_q.dq_out;
  assign data_io_lines_oe = pins_q.dq_oe;

  // ****************************************
  // Checks
  // ****************************************
  logic [TMR_W-1:0] pd_low_cnt_q;
  logic [TMR_W-1:0] wake_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (rst || pins_q.power_down_reset_n) begin
      pd_low_cnt_q <= '0;
    end else if (pd_low_cnt_q != TMR_RST_VAL) begin
      pd_low_cnt_q <= pd_low_cnt_q + TMR_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !pins_q.power_down_reset_n) begin
      wake_cnt_q <= '0;
    end else if (wake_cnt_q != TMR_RST_VAL) begin
      wake_cnt_q <= wake_cnt_q + TMR_ONE;
    end
  end

  no_oe_we_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(!pins_q.oe_n && !pins_q.we_n))
    else $error("output enable and write strobe low together");

  read_pins_a: assert property (@(posedge clk_sys) disable iff (rst)
    !pins_q.oe_n |-> (!pins_q.chip_select_a_n && !pins_q.chip_select_b_n
                      && pins_q.we_n && pins_q.power_down_reset_n))
    else $error("read cycle with wrong control levels");

  pd_min_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(pins_q.power_down_reset_n) |-> pd_low_cnt_q >= PD_HOLD_CYC)
    else $error("power-down pulse shorter than minimum");

  wake_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(pins_q.oe_n) |-> wake_cnt_q >= WAKE_OUT_CYC)
    else $error("read started before wake-to-output delay");

  wake_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(pins_q.we_n) |-> wake_cnt_q >= WAKE_WR_CYC)
    else $error("write started before wake-to-write delay");

  reset_pd_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> !pins_q.power_down_reset_n ##1 !pins_q.power_down_reset_n)
    else $error("system reset did not hold flash in power-down");

  addr_stable_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!pins_q.we_n && $past(!pins_q.we_n)) |-> ($stable(pins_q.addr)
                                               && $stable(pins_q.dq_out)))
    else $error("address or data moved during write strobe");

  strobe_first_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(pins_q.we_n) |-> !pins_q.chip_select_a_n && pins_q.dq_oe[0])
    else $error("select or data released before write strobe rose");

  read_done_c: cover property (@(posedge clk_sys) disable iff (rst) resp_valid_q);
  write_done_c: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(pins_q.we_n) ##[1:20] pins_q.chip_select_a_n);
  pwrdn_c: cover property (@(posedge clk_sys) disable iff (rst)
    $fell(pins_q.power_down_reset_n));

endmodule

// ==== bench/afb_flash_model.sv ====
// Behavioural flash device model answering the host controller's pins
`timescale 1ns/1ps
module afb_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00A5, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h005A, // Arbitrary value
  parameter int BUSY_NS = 2000,
  // Program supply above its lockout level
  parameter logic PROG_SUPPLY_OK = 1'b1
) (
  input wire logic [20:0] flash_addr,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic power_down_reset_n,
  input wire logic byte_wide,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_oe,
  output logic busy_low
);
  logic [15:0] mem [int];
  logic lock [int];
  logic [7:0] mode_q = 8'hFF;
  logic [7:0] setup_q = 8'h00;
  logic [7:0] status_q = 8'h80;
  logic wr_act;
  logic rd_act;
  int wa;
  int blk;
  initial busy_low = 1'b0;
  // ****************************************
  // Command capture
  // ****************************************
  // Falls on whichever of strobe or select rises first
  assign wr_act = !we_n && !chip_select_a_n && !chip_select_b_n && power_down_reset_n;
  always @(negedge wr_act) begin
    wa = int'(flash_addr[20:1]);
    blk = int'(flash_addr[20:16]);
    if (setup_q == 8'h40) begin
      if (!lock.exists(blk) && PROG_SUPPLY_OK) begin
        mem[wa] = dq_in;
        busy_low = 1'b1;
      end
      mode_q = 8'h70;
    end else if (setup_q == 8'h60 && dq_in[7:0] == 8'h01) begin
      lock[blk] = 1'b1;
    end else if (dq_in[7:0] inside {8'hFF, 8'h90, 8'h98, 8'h70}) begin
      mode_q = dq_in[7:0];
    end
    setup_q = (setup_q == 8'h00 && dq_in[7:0] inside {8'h40, 8'h60}) ? dq_in[7:0] : 8'h00;
  end
  // Busy runs on regardless of select
  always @(posedge busy_low) begin
    #(BUSY_NS);
    busy_low = 1'b0;
  end
  always @(negedge power_down_reset_n) begin
    if (busy_low) begin
      #100;
      busy_low = 1'b0;
    end
  end
  always @(posedge power_down_reset_n) begin
    mode_q = 8'hFF;
    status_q = 8'h80;
    setup_q = 8'h00;
  end
  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    int ra;
    logic [15:0] w;
    w = 16'hFFFF;
    ra = int'(flash_addr[20:1]);
    case (mode_q)
      8'h90: w = (ra % 32768 == 0) ? MAKER_CODE : (ra % 32768 == 1) ? DEVICE_CODE :
        {15'h0000, lock.exists(ra / 32768) != 0};
      8'h98: w = {8'h00, 8'(ra % 48) ^ 8'h5A};
      8'h70: w = {8'h00, busy_low ? 8'h00 : status_q};
      default: w = mem.exists(ra) ? mem[ra] : 16'hFFFF;
    endcase
    rd_act = power_down_reset_n && !chip_select_a_n && !chip_select_b_n && !oe_n && we_n;
    dq_out = byte_wide ? w : {8'h00, flash_addr[0] ? w[15:8] : w[7:0]};
    dq_oe = !rd_act ? 16'h0000 : (mode_q == 8'h98 || !byte_wide) ? 16'h00FF : 16'hFFFF;
  end
endmodule

// ==== bench/async_flash_bus_interface_test.sv ====
// Self-checking bench for the async flash host controller
`timescale 1ns/1ps
module async_flash_bus_interface_test;
  import afb_pkg::*;
  localparam logic [15:0] MAKER = 16'h00A5; // Arbitrary value
  localparam logic [15:0] DEVICE = 16'h005A; // Arbitrary value
  logic clk_sys, rst, req_valid, req_ready, resp_valid, dev_busy, rb_w, busy_low;
  logic cs_a_n, cs_b_n, oe_n, we_n, pd_n, byte_wide;
  afb_req_t req;
  logic [15:0] resp_data, dq_out, dq_oe, m_out, m_oe, dq_w, d, got;
  logic [15:0] float_q = 16'h5A3C;
  logic [20:0] flash_addr, a, b;
  logic [15:0] ref_mem [int];
  logic [20:0] id_a [4] = '{21'h000000, 21'h000002, 21'h1F0004, 21'h000000};
  logic [15:0] id_e [4] = '{MAKER, DEVICE, 16'h0001, MAKER};
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed, i, n;
  afb_host DUT (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_data(resp_data), .dev_busy(dev_busy), .flash_addr(flash_addr),
    .chip_select_a_n(cs_a_n), .chip_select_b_n(cs_b_n), .oe_n(oe_n), .we_n(we_n),
    .power_down_reset_n(pd_n), .byte_wide(byte_wide), .data_io_lines_in(dq_w),
    .data_io_lines_out(dq_out), .data_io_lines_oe(dq_oe), .ready_busy_output(rb_w));
  afb_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) flash (
    .flash_addr(flash_addr), .chip_select_a_n(cs_a_n), .chip_select_b_n(cs_b_n), .oe_n(oe_n),
    .we_n(we_n), .power_down_reset_n(pd_n), .byte_wide(byte_wide), .dq_in(dq_w),
    .dq_out(m_out), .dq_oe(m_oe), .busy_low(busy_low));
  // Undriven data bits wander so a stale value never passes
  assign dq_w = dq_oe[0] ? dq_out : (m_oe & m_out) | (~m_oe & float_q);
  assign rb_w = busy_low ? 1'b0 : 1'b1;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) float_q <= ~float_q;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] exp, input logic [15:0] act);
    tests_run++;
    if (act !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, act);
    end
  endtask
  function automatic logic [15:0] ref_rd(input logic [20:0] ad);
    return ref_mem.exists(int'(ad[20:1])) ? ref_mem[int'(ad[20:1])] : 16'hFFFF;
  endfunction
  task automatic do_req(input afb_op_t op, input logic [20:0] ad, input logic [15:0] dt,
                        input logic w);
    int k;
    k = 0;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{op: op, addr: ad, data: dt, wide: w};
    while (req_ready !== 1'b1 && k < 1000) begin
      @(negedge clk_sys);
      k++;
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    k = 0;
    while (op == OP_READ && resp_valid !== 1'b1 && k < 50) begin
      @(negedge clk_sys);
      k++;
    end
    got = resp_data;
  endtask
  task automatic wait_busy();
    n = 0;
    while (dev_busy !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check(16'h0001, {15'h0000, dev_busy});
    while (dev_busy === 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 77443;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    for (i = 0; i < 4; i++) begin
      a = 21'($random(seed));
      do_req(OP_READ, a, 16'h0000, 1'b1);
      check(ref_rd(a), got);
    end
    $display("test wake read done");
    for (i = 0; i < 3; i++) begin
      a = {5'(i), 16'($random(seed))};
      d = 16'($random(seed));
      b = (i == 0) ? a : b;
      do_req(OP_WRITE, a, 16'h0040, 1'b1);
      do_req(OP_WRITE, a, d, 1'b1);
      wait_busy();
      do_req(OP_READ, a, 16'h0000, 1'b1);
      check(16'h0080, got);
      do_req(OP_WRITE, a, 16'h00FF, 1'b1);
      ref_mem[int'(a[20:1])] = d;
      do_req(OP_WRITE, a, 16'hC3C3, 1'b1);
      do_req(OP_READ, a, 16'h0000, 1'b1);
      check(ref_rd(a), got);
      do_req(OP_READ, a | 21'h000001, 16'h0000, 1'b0);
      check({8'h00, d[15:8]}, got);
      do_req(OP_READ, a & 21'h1FFFFE, 16'h0000, 1'b0);
      check({8'h00, d[7:0]}, got);
    end
    $display("test program done");
    a = {5'h1F, 16'($random(seed))};
    do_req(OP_WRITE, a, 16'h0060, 1'b1);
    do_req(OP_WRITE, a, 16'h0001, 1'b1);
    do_req(OP_WRITE, a, 16'h0040, 1'b1);
    do_req(OP_WRITE, a, 16'h1234, 1'b1);
    do_req(OP_WRITE, a, 16'h00FF, 1'b1);
    do_req(OP_READ, a, 16'h0000, 1'b1);
    check(16'hFFFF, got);
    do_req(OP_WRITE, 21'h000000, 16'h0090, 1'b1);
    for (i = 0; i < 4; i++) begin
      do_req(OP_READ, id_a[i], 16'h0000, 1'b1);
      check(id_e[i], got);
    end
    do_req(OP_WRITE, 21'h000000, 16'h0098, 1'b1);
    for (i = 0; i < 3; i++) begin
      a = 21'($random(seed));
      do_req(OP_READ, a, 16'h0000, 1'b1);
      check({8'h00, 8'(int'(a[20:1]) % 48) ^ 8'h5A}, {8'h00, got[7:0]});
    end
    $display("test modes done");
    a = {5'h03, 16'($random(seed))};
    do_req(OP_WRITE, a, 16'h00FF, 1'b1);
    do_req(OP_WRITE, a, 16'h0040, 1'b1);
    do_req(OP_WRITE, a, 16'h5555, 1'b1);
    do_req(OP_PWRDN, 21'h000000, 16'h0000, 1'b1);
    do_req(OP_READ, b, 16'h0000, 1'b1);
    check(ref_rd(b), got);
    check(16'h0000, {15'h0000, dev_busy});
    do_req(OP_WRITE, b, 16'h0070, 1'b1);
    do_req(OP_READ, b, 16'h0000, 1'b1);
    check(16'h0080, got);
    $display("test abort done");
    print_verdict();
  end
endmodule
